// ==== hdl/adc_conversion_sequencer.sv ====
// digital sequencer of a delta-sigma converter: clock source, state timing,
// result word formatting and serial data output.
// assumes the filter delivers one code per conversion on a valid/ready pair
// and the serial input logic supplies the configuration strobe.
module adc_conversion_sequencer #(
    parameter int unsigned POR_CYCLES   = adc_seq_pkg::POR_CYC,
    parameter int unsigned C60_1X       = adc_seq_pkg::CONV_60_1X_CYC,
    parameter int unsigned C60_2X       = adc_seq_pkg::CONV_60_2X_CYC,
    parameter int unsigned C50_1X       = adc_seq_pkg::CONV_50_1X_CYC,
    parameter int unsigned C50_2X       = adc_seq_pkg::CONV_50_2X_CYC,
    parameter int unsigned C5060_1X     = adc_seq_pkg::CONV_5060_1X_CYC,
    parameter int unsigned C5060_2X     = adc_seq_pkg::CONV_5060_2X_CYC,
    parameter int unsigned EXT_1X       = adc_seq_pkg::EXT_CONV_1X,
    parameter int unsigned EXT_2X       = adc_seq_pkg::EXT_CONV_2X,
    parameter int unsigned DOUT_MAX_CYC = adc_seq_pkg::DOUT_MAX_CYC
) (
    // clock and reset
    input  wire logic        CLK_SYS,
    input  wire logic        RESET_N,
    // conversion clock pin
    input  wire logic        CONV_CLOCK_PIN,
    // serial port
    input  wire logic        CS_N,
    input  wire logic        SCK_IN,
    output logic             SCK_OUT,
    output logic             SCK_OE,
    output logic             SDO_OUT,
    output logic             SDO_OE,
    // configuration from the serial input logic
    input  wire logic        CFG_WR,
    input  wire logic [1:0]  CFG_REJ,
    input  wire logic        CFG_SPD,
    // filter side
    input  wire logic        RES_VALID,
    input  wire logic [29:0] RES_CODE,
    input  wire logic        RES_OVER,
    input  wire logic        RES_UNDER,
    output logic             RES_READY,
    output logic             CONV_START,
    output logic             FILTER_TICK,
    output logic             CAL_PHASE,
    output logic             INT_OSC_EN,
    output logic [1:0]       REJ_MODE,
    output logic             SPEED_2X
);
    localparam int CW = adc_seq_pkg::CNT_W;
    localparam int TICK_CYC = int'(DOUT_MAX_CYC / adc_seq_pkg::DOUT_TICKS);

    logic                      rst_ff1;
    logic                      rst_n_s;
    logic [2:0]                pins_s;
    logic [2:0]                pins_prev_reg;
    logic [adc_seq_pkg::DET_W-1:0] act_cnt_reg;
    logic                      ext_reg;
    logic                      src_reg;
    logic [15:0]               tick_cnt_reg;
    adc_seq_pkg::state_e       state_reg;
    adc_seq_pkg::state_e       state_next;
    logic [CW-1:0]             cnt_reg;
    logic [CW-1:0]             por_cnt_reg;
    logic [1:0]                rej_reg;
    logic                      spd_reg;
    logic [31:0]               shift_reg;
    logic [4:0]                bit_cnt_reg;
    logic [1:0]                sck_div_reg;
    logic                      int_mode_reg;
    logic                      tog_reg;

    stream_if #(.W(adc_seq_pkg::WORD_BITS)) res_in ();
    stream_if #(.W(adc_seq_pkg::WORD_BITS)) res_out ();

    always_ff @(posedge CLK_SYS or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            rst_ff1 <= 1'b0;
            rst_n_s <= 1'b0;
        end
        else
        begin
            rst_ff1 <= 1'b1;
            rst_n_s <= rst_ff1;
        end
    end

    sync3 #(.W(3), .INIT(adc_seq_pkg::PINS_INIT)) u_sync (
        .clk   (CLK_SYS),
        .rst_n (rst_n_s),
        .d     ({CS_N, SCK_IN, CONV_CLOCK_PIN}),
        .q     (pins_s)
    );

    wire cs_n_s   = pins_s[2];
    wire sck_s    = pins_s[1];
    wire f0_s     = pins_s[0];
    wire cs_fall  = pins_prev_reg[2] & ~cs_n_s;
    wire sck_rise = ~pins_prev_reg[1] & sck_s;
    wire sck_fall = pins_prev_reg[1] & ~sck_s;
    wire f0_edge  = pins_prev_reg[0] ^ f0_s;
    wire f0_rise  = ~pins_prev_reg[0] & f0_s;

    // presence timeout counts system cycles; a slower clock reads as absent
    wire act_timeout = act_cnt_reg == adc_seq_pkg::DET_W'(adc_seq_pkg::DET_TIMEOUT_CYC - 1);
    wire int_tick    = ~ext_reg & (tick_cnt_reg == 16'(TICK_CYC - 1));
    wire conv_tick   = ext_reg ? f0_rise : int_tick;

    // conversion length by source, rejection and speed
    wire [CW-1:0] len_1x = (rej_reg == adc_seq_pkg::REJ_60) ? CW'(C60_1X)
                         : (rej_reg == adc_seq_pkg::REJ_50) ? CW'(C50_1X)
                         : CW'(C5060_1X);
    wire [CW-1:0] len_2x = (rej_reg == adc_seq_pkg::REJ_60) ? CW'(C60_2X)
                         : (rej_reg == adc_seq_pkg::REJ_50) ? CW'(C50_2X)
                         : CW'(C5060_2X);
    wire [CW-1:0] ext_len  = spd_reg ? CW'(EXT_2X) : CW'(EXT_1X);
    wire [CW-1:0] conv_len = src_reg ? ext_len : (spd_reg ? len_2x : len_1x);
    wire          conv_inc = src_reg ? f0_rise : 1'b1;
    wire          conv_done  = cnt_reg == conv_len;
    wire          src_change = src_reg != ext_reg;
    wire          por_done   = por_cnt_reg == CW'(POR_CYCLES - 1);

    // serial output events; shifting counts edges, not time
    wire int_fall = int_mode_reg & conv_tick & (sck_div_reg == adc_seq_pkg::SCK_HALF_LAST)
                  & SCK_OUT;
    wire in_dout  = state_reg == adc_seq_pkg::ST_DOUT;
    wire shift_ev = in_dout & (int_mode_reg ? int_fall : sck_fall);
    wire last_bit = shift_ev & (bit_cnt_reg == adc_seq_pkg::LAST_BIT);
    wire dout_go  = ~cs_n_s & ~cs_fall & (int_mode_reg | sck_rise);
    wire pop      = (state_reg == adc_seq_pkg::ST_CONV) & conv_done & res_out.valid;
    wire start    = (state_next == adc_seq_pkg::ST_CONV) & (state_reg != adc_seq_pkg::ST_CONV);

    // result formatting
    wire        code_zero = RES_CODE == '0;
    wire        sign_bit  = (code_zero & spd_reg) ? tog_reg : ~RES_CODE[29];
    wire [31:0] word_norm = {2'b00, sign_bit, RES_CODE[28:0]};
    wire [31:0] word_over = {adc_seq_pkg::OVER_HEAD, 28'h0000000};
    wire [31:0] word_undr = {adc_seq_pkg::UNDER_HEAD, 28'hFFFFFFF};
    wire [31:0] fmt_word  = RES_OVER ? word_over : (RES_UNDER ? word_undr : word_norm);
    wire        res_push  = RES_VALID & res_in.ready;

    assign res_in.valid  = RES_VALID;
    assign res_in.data   = fmt_word;
    assign res_out.ready = pop;
    assign RES_READY     = res_in.ready;
    assign REJ_MODE      = rej_reg;
    assign SPEED_2X      = spd_reg;

    fifo_buf #(.W(adc_seq_pkg::WORD_BITS), .DEPTH(adc_seq_pkg::FIFO_DEPTH)) u_fifo (
        .clk   (CLK_SYS),
        .rst_n (rst_n_s),
        .wr    (res_in.snk),
        .rd    (res_out.src)
    );

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            adc_seq_pkg::ST_POR:
                if (por_done)
                    state_next = adc_seq_pkg::ST_CONV;
            adc_seq_pkg::ST_CONV:
                if (pop)
                    state_next = adc_seq_pkg::ST_SLEEP;
            adc_seq_pkg::ST_SLEEP:
                if (dout_go)
                    state_next = adc_seq_pkg::ST_DOUT;
            adc_seq_pkg::ST_DOUT:
                if (cs_n_s | last_bit)
                    state_next = adc_seq_pkg::ST_CONV;
            default:
                state_next = adc_seq_pkg::ST_POR;
        endcase
    end

    always_ff @(posedge CLK_SYS or negedge rst_n_s)
    begin
        if (!rst_n_s)
        begin
            state_reg     <= adc_seq_pkg::ST_POR;
            pins_prev_reg <= adc_seq_pkg::PINS_INIT;
            por_cnt_reg   <= '0;
        end
        else
        begin
            state_reg     <= state_next;
            pins_prev_reg <= pins_s;
            por_cnt_reg   <= por_done ? por_cnt_reg : por_cnt_reg + 1'b1;
        end
    end

    // external clock presence; any edge re-arms the timeout
    always_ff @(posedge CLK_SYS or negedge rst_n_s)
    begin
        if (!rst_n_s)
        begin
            act_cnt_reg  <= '0;
            ext_reg      <= 1'b0;
            src_reg      <= 1'b0;
            tick_cnt_reg <= '0;
        end
        else
        begin
            act_cnt_reg  <= (f0_edge | act_timeout) ? '0 : act_cnt_reg + 1'b1;
            ext_reg      <= f0_edge | (ext_reg & ~act_timeout);
            src_reg      <= ext_reg;
            tick_cnt_reg <= (int_tick | ext_reg) ? '0 : tick_cnt_reg + 1'b1;
        end
    end

    // conversion timer; a source change restarts it so only this result suffers
    always_ff @(posedge CLK_SYS or negedge rst_n_s)
    begin
        if (!rst_n_s)
            cnt_reg <= '0;
        else if (start | src_change)
            cnt_reg <= '0;
        else if ((state_reg == adc_seq_pkg::ST_CONV) & conv_inc & ~conv_done)
            cnt_reg <= cnt_reg + 1'b1;
    end

    // configuration written outside ST_CONV is loaded at the next clock; writes during a conversion or with REJ_RSVD are dropped
    always_ff @(posedge CLK_SYS or negedge rst_n_s)
    begin
        if (!rst_n_s)
        begin
            rej_reg <= adc_seq_pkg::REJ_5060;
            spd_reg <= 1'b0;
        end
        else if (CFG_WR & (CFG_REJ != adc_seq_pkg::REJ_RSVD) & (state_reg != adc_seq_pkg::ST_CONV))
        begin
            rej_reg <= CFG_REJ;
            spd_reg <= CFG_SPD;
        end
    end

    always_ff @(posedge CLK_SYS or negedge rst_n_s)
    begin
        if (!rst_n_s)
            tog_reg <= 1'b0;
        else if (res_push & code_zero & spd_reg)
            tog_reg <= ~tog_reg;
    end

    // output shift register, loaded once per conversion
    always_ff @(posedge CLK_SYS or negedge rst_n_s)
    begin
        if (!rst_n_s)
        begin
            shift_reg   <= '1;
            bit_cnt_reg <= '0;
        end
        else if (pop)
        begin
            shift_reg   <= res_out.data;
            bit_cnt_reg <= '0;
        end
        else if (shift_ev)
        begin
            shift_reg   <= {shift_reg[30:0], 1'b1};
            bit_cnt_reg <= bit_cnt_reg + 1'b1;
        end
    end

    // internal SCK: 4 ticks high, 4 low, so 32 bits fit in 256 ticks
    always_ff @(posedge CLK_SYS or negedge rst_n_s)
    begin
        if (!rst_n_s)
        begin
            int_mode_reg <= 1'b0;
            sck_div_reg  <= '0;
            SCK_OUT      <= 1'b0;
        end
        else
        begin
            if (cs_fall)
                int_mode_reg <= sck_s;
            if (~in_dout | ~int_mode_reg)
            begin
                sck_div_reg <= '0;
                SCK_OUT     <= 1'b0;
            end
            else if (conv_tick)
            begin
                sck_div_reg <= sck_div_reg + 1'b1;
                if (sck_div_reg == adc_seq_pkg::SCK_HALF_LAST)
                    SCK_OUT <= ~SCK_OUT;
            end
        end
    end

    // registered pin and filter outputs
    always_ff @(posedge CLK_SYS or negedge rst_n_s)
    begin
        if (!rst_n_s)
        begin
            SDO_OUT     <= 1'b1;
            SDO_OE      <= 1'b0;
            SCK_OE      <= 1'b0;
            CONV_START  <= 1'b0;
            FILTER_TICK <= 1'b0;
            CAL_PHASE   <= 1'b0;
            INT_OSC_EN  <= 1'b1;
        end
        else
        begin
            SDO_OUT     <= (state_next == adc_seq_pkg::ST_CONV)
                         | (state_next == adc_seq_pkg::ST_POR)
                         | (pop ? res_out.data[31] : (shift_ev ? shift_reg[30] : shift_reg[31]));
            SDO_OE      <= ~cs_n_s;
            SCK_OE      <= ~cs_n_s & int_mode_reg;
            CONV_START  <= start;
            FILTER_TICK <= conv_tick & (state_reg == adc_seq_pkg::ST_CONV);
            CAL_PHASE   <= (state_reg == adc_seq_pkg::ST_CONV) & ~spd_reg
                         & (cnt_reg >= (conv_len >> 1));
            INT_OSC_EN  <= ~ext_reg;
        end
    end

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!rst_n_s);

    property p_rej_default;
        (state_reg == adc_seq_pkg::ST_POR) |-> (rej_reg == adc_seq_pkg::REJ_5060);
    endproperty
    a_rej_default: assert property (p_rej_default)
        else $error("rejection not combined during reset");

    property p_osc_off;
        $rose(ext_reg) |=> !INT_OSC_EN;
    endproperty
    a_osc_off: assert property (p_osc_off)
        else $error("oscillator still on with external clock");

    property p_absent;
        (ext_reg && act_timeout && !f0_edge) |=> !ext_reg ##1 INT_OSC_EN;
    endproperty
    a_absent: assert property (p_absent)
        else $error("external clock not dropped after timeout");

    property p_sleep_hold;
        (state_reg == adc_seq_pkg::ST_SLEEP && cs_n_s) |=> (state_reg == adc_seq_pkg::ST_SLEEP);
    endproperty
    a_sleep_hold: assert property (p_sleep_hold)
        else $error("left sleep with chip select high");

    property p_last_fall;
        last_bit |=> (state_reg == adc_seq_pkg::ST_CONV) && SDO_OUT && CONV_START
                     ##1 !CONV_START;
    endproperty
    a_last_fall: assert property (p_last_fall)
        else $error("no new conversion after last falling edge");

    property p_abort;
        (in_dout && cs_n_s) |=> (state_reg == adc_seq_pkg::ST_CONV) && $past(start);
    endproperty
    a_abort: assert property (p_abort)
        else $error("chip select high did not abort output");

    property p_one_word;
        pop |=> (state_reg == adc_seq_pkg::ST_SLEEP) && !SDO_OUT;
    endproperty
    a_one_word: assert property (p_one_word)
        else $error("conversion end did not load one word");

    property p_over;
        (RES_VALID && RES_OVER) |-> (fmt_word == {adc_seq_pkg::OVER_HEAD, 28'h0000000});
    endproperty
    a_over: assert property (p_over)
        else $error("overrange pattern wrong");

    property p_zero_toggle;
        (res_push && code_zero && spd_reg) |=> (tog_reg != $past(tog_reg));
    endproperty
    a_zero_toggle: assert property (p_zero_toggle)
        else $error("sign did not toggle on zero code");

    property p_conv_bound;
        (state_reg == adc_seq_pkg::ST_CONV) |-> (cnt_reg <= conv_len);
    endproperty
    a_conv_bound: assert property (p_conv_bound)
        else $error("conversion counter overran its length");

    c_por_exit: cover property ($fell(state_reg == adc_seq_pkg::ST_POR));
    c_full_word: cover property (last_bit);
    c_abort: cover property (in_dout && cs_n_s);
    c_ext_clock: cover property ($rose(ext_reg));
endmodule

// ==== hdl/adc_seq_pkg.sv ====
// constants, states and word layout for the conversion sequencer
// assumes a 10 MHz system clock; times are held in microseconds
package adc_seq_pkg;
    localparam int unsigned CLK_HZ        = 10_000_000;
    localparam int unsigned CYC_PER_US    = CLK_HZ / 1_000_000;
    localparam int unsigned POR_TIME_US   = 4000;
    localparam int unsigned POR_CYC       = POR_TIME_US * CYC_PER_US;
    // internal oscillator conversion times
    localparam int unsigned CONV_60_1X_US   = 133000;
    localparam int unsigned CONV_60_2X_US   = 67000;
    localparam int unsigned CONV_50_1X_US   = 160000;
    localparam int unsigned CONV_50_2X_US   = 80000;
    localparam int unsigned CONV_5060_1X_US = 147000;
    localparam int unsigned CONV_5060_2X_US = 73600;
    localparam int unsigned CONV_60_1X_CYC   = CONV_60_1X_US * CYC_PER_US;
    localparam int unsigned CONV_60_2X_CYC   = CONV_60_2X_US * CYC_PER_US;
    localparam int unsigned CONV_50_1X_CYC   = CONV_50_1X_US * CYC_PER_US;
    localparam int unsigned CONV_50_2X_CYC   = CONV_50_2X_US * CYC_PER_US;
    localparam int unsigned CONV_5060_1X_CYC = CONV_5060_1X_US * CYC_PER_US;
    localparam int unsigned CONV_5060_2X_CYC = CONV_5060_2X_US * CYC_PER_US;
    // external conversion clock, in its own periods
    localparam int unsigned EXT_CONV_1X   = 41036;
    localparam int unsigned EXT_CONV_2X   = 20556;
    localparam int unsigned EXT_NOTCH_DIV = 5120;
    // presence detection: one period of the slowest legal clock
    localparam int unsigned DET_MIN_HZ      = 10_000;
    localparam int unsigned DET_TIMEOUT_CYC = CLK_HZ / DET_MIN_HZ;
    localparam int          DET_W           = 11;
    // data output limit with the internal oscillator
    localparam int unsigned DOUT_MAX_US   = 830;
    localparam int unsigned DOUT_MAX_CYC  = DOUT_MAX_US * CYC_PER_US;
    localparam int unsigned DOUT_TICKS    = 256;
    localparam logic [1:0]  SCK_HALF_LAST = 2'h3;
    localparam logic [4:0]  LAST_BIT      = 5'h1F;
    localparam int          CNT_W         = 21;
    localparam int          WORD_BITS     = 32;
    localparam int          CODE_BITS     = 30;
    localparam int          FIFO_DEPTH    = 32;
    localparam logic [3:0]  OVER_HEAD     = 4'h3;
    localparam logic [3:0]  UNDER_HEAD    = 4'h0;
    localparam logic [2:0]  PINS_INIT     = 3'h4;

    typedef enum logic [1:0] {
        ST_POR   = 2'b00,
        ST_CONV  = 2'b01,
        ST_SLEEP = 2'b11,
        ST_DOUT  = 2'b10
    } state_e;

    typedef enum logic [1:0] {
        REJ_5060 = 2'b00,
        REJ_50   = 2'b01,
        REJ_60   = 2'b10,
        REJ_RSVD = 2'b11
    } rej_e;
endpackage

// ==== hdl/fifo_buf.sv ====
// result word buffer with registered write-side ready
// assumes one clock; reader may stall so the writer sees full
module fifo_buf #(
    parameter int W     = 32,
    parameter int DEPTH = 32
) (
    input  wire logic clk,
    input  wire logic rst_n,
    stream_if.snk     wr,
    stream_if.src     rd
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wp_reg;
    logic [AW-1:0] rp_reg;
    logic [AW:0]   cnt_reg;
    logic          not_full_reg;

    wire          push     = wr.valid & not_full_reg;
    wire          pop      = rd.valid & rd.ready;
    wire [AW:0]   cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);

    assign wr.ready = not_full_reg;
    assign rd.valid = cnt_reg != '0;
    assign rd.data  = mem[rp_reg];

    always_ff @(posedge clk)
    begin
        if (push)
            mem[wp_reg] <= wr.data;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wp_reg       <= '0;
            rp_reg       <= '0;
            cnt_reg      <= '0;
            not_full_reg <= 1'b0;
        end
        else
        begin
            wp_reg       <= wp_reg + AW'(push);
            rp_reg       <= rp_reg + AW'(pop);
            cnt_reg      <= cnt_next;
            not_full_reg <= cnt_next != (AW+1)'(DEPTH);
        end
    end
endmodule

// ==== hdl/stream_if.sv ====
// valid/ready word stream between the sequencer and its buffer
// assumes both ends run on the system clock
interface stream_if #(parameter int W = 32);
    logic [W-1:0] data;
    logic         valid;
    logic         ready;
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface

// ==== hdl/sync3.sv ====
// three-stage synchroniser with agreement filter, one lane per bit
// assumes asynchronous inputs and a synchronous-release reset
module sync3 #(
    parameter int           W    = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] ff1;
    logic [W-1:0] ff2;
    logic [W-1:0] ff3;
    wire  [W-1:0] agree = ~(ff2 ^ ff3);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ff1 <= INIT;
            ff2 <= INIT;
            ff3 <= INIT;
            q   <= INIT;
        end
        else
        begin
            ff1 <= d;
            ff2 <= ff1;
            ff3 <= ff2;
            q   <= (agree & ff3) | (~agree & q);
        end
    end
endmodule

// ==== tb/adc_conversion_sequencer_bench.sv ====
// bench for the conversion sequencer: word formats, config, clock source
// assumes the serial host model and shortened counts
module adc_conversion_sequencer_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0, rst_n = 1'b0, ext_on = 1'b0;
    logic [3:0]  ext_cnt = 4'h0;
    logic        cs_n, sck, sdo, sdo_oe, res_ready, osc_en, spd_2x;
    logic        sck_out, sck_oe, conv_start;
    int          starts = 0;
    logic        cfg_wr = 1'b0, cfg_spd = 1'b0, res_valid = 1'b0;
    logic        res_over = 1'b0, res_under = 1'b0;
    logic [1:0]  cfg_rej = 2'h0, rej_mode;
    logic [29:0] res_code = 30'h0;
    int          mismatches = 0, comparisons = 0;
    always #50 clk = ~clk;
    always @(posedge clk)
        if (ext_on)
            ext_cnt <= ext_cnt + 4'h1;
    always @(posedge clk)
        if (conv_start === 1'b1)
            starts++;
    adc_conversion_sequencer #(.POR_CYCLES(50), .C5060_1X(200), .C60_2X(100), .EXT_2X(20))
        adc_conversion_sequencer_inst (
        .CLK_SYS(clk), .RESET_N(rst_n), .CONV_CLOCK_PIN(ext_cnt[3]), .CS_N(cs_n),
        .SCK_IN(sck), .SCK_OUT(sck_out), .SCK_OE(sck_oe), .SDO_OUT(sdo), .SDO_OE(sdo_oe),
        .CFG_WR(cfg_wr), .CFG_REJ(cfg_rej), .CFG_SPD(cfg_spd), .RES_VALID(res_valid),
        .RES_CODE(res_code), .RES_OVER(res_over), .RES_UNDER(res_under),
        .RES_READY(res_ready), .CONV_START(conv_start), .FILTER_TICK(), .CAL_PHASE(),
        .INT_OSC_EN(osc_en), .REJ_MODE(rej_mode), .SPEED_2X(spd_2x));
    serial_host_model serial_host_model_inst (.clk(clk), .cs_n(cs_n), .sck(sck),
        .sdo(sdo), .sdo_oe(sdo_oe), .sck_out(sck_out), .sck_oe(sck_oe));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic push(input logic [29:0] code, input logic ov, input logic un);
        @(posedge clk);
        res_code <= code;
        res_over <= ov;
        res_under <= un;
        res_valid <= 1'b1;
        @(posedge clk);
        while (res_ready !== 1'b1)
            @(posedge clk);
        res_valid <= 1'b0;
    endtask
    task automatic read(input logic [31:0] exp);
        logic        ok, eoc;
        logic [31:0] w;
        serial_host_model_inst.wait_ready(ok);
        check({31'h0, ok}, 32'h1);
        serial_host_model_inst.read_word(w, eoc);
        check(w, exp);
        check({31'h0, eoc}, 32'h1);
    endtask
    task automatic cfg(input logic [1:0] rej, input logic spd);
        @(posedge clk);
        cfg_rej <= rej;
        cfg_spd <= spd;
        cfg_wr <= 1'b1;
        @(posedge clk);
        cfg_wr <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    task automatic t_words;
        push(30'h0ABCDE1F, 1'b0, 1'b0);
        read(32'h2ABCDE1F);
        push(30'h00000000, 1'b0, 1'b0);
        read(32'h20000000);
        push(30'h00000000, 1'b1, 1'b1);
        read(32'h30000000);
        push(30'h00000000, 1'b0, 1'b1);
        read(32'h0FFFFFFF);
        check(starts, 32'h5);
        $display("test words done");
    endtask
    task automatic t_zero;
        push(30'h00000000, 1'b0, 1'b0);
        read(32'h00000000);
        push(30'h00000000, 1'b0, 1'b0);
        read(32'h20000000);
        $display("test zero sign done");
    endtask
    task automatic t_int;
        logic        ok, eoc;
        logic [31:0] w;
        push(30'h01234567, 1'b0, 1'b0);
        serial_host_model_inst.read_int(w, eoc, ok);
        check({31'h0, ok}, 32'h1);
        check(w, 32'h21234567);
        check({31'h0, eoc}, 32'h1);
        $display("test internal clock done");
    endtask
    task automatic t_cfg;
        logic ok;
        push(30'h05555555, 1'b0, 1'b0);
        serial_host_model_inst.wait_ready(ok);
        cfg(2'h3, 1'b1);
        check({29'h0, rej_mode, spd_2x}, 32'h0);
        cfg(2'h2, 1'b1);
        check({29'h0, rej_mode, spd_2x}, 32'h5);
        read(32'h25555555);
        $display("test config done");
    endtask
    task automatic t_ext;
        ext_on <= 1'b1;
        push(30'h3FFFFFFF, 1'b0, 1'b0);
        repeat (100) @(posedge clk);
        check({31'h0, osc_en}, 32'h0);
        read(32'h1FFFFFFF);
        ext_on <= 1'b0;
        repeat (1100) @(posedge clk);
        check({31'h0, osc_en}, 32'h1);
        $display("test clock source done");
    endtask
    initial
    begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (5) @(posedge clk);
        check({29'h0, rej_mode, spd_2x}, 32'h0);
        check({31'h0, osc_en}, 32'h1);
        t_words;
        t_cfg;
        t_zero;
        t_int;
        t_ext;
        stop_test;
    end
    initial
    begin
        repeat (40000) @(posedge clk);
        mismatches++;
        stop_test;
    end
endmodule

// ==== tb/serial_host_model.sv ====
// serial host model: reads result words with its own serial clock or the device driven one
// assumes output mode is picked by the serial clock level at select fall, high for internal
module serial_host_model (
    // system clock
    input  wire logic clk,
    // serial port
    output logic      cs_n,
    output logic      sck,
    input  wire logic sdo,
    input  wire logic sdo_oe,
    // device driven serial clock
    input  wire logic sck_out,
    input  wire logic sck_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        cs_n = 1'b1;
        sck  = 1'b0;
    end
    task automatic wait_ready(output logic ok);
        ok = 1'b0;
        repeat (8) @(posedge clk);
        cs_n <= 1'b0;
        repeat (5000)
            if (!ok)
            begin
                @(posedge clk);
                ok = (sdo_oe === 1'b1) && (sdo === 1'b0);
            end
    endtask
    // slow halves so the input synchroniser sees every edge
    task automatic read_word(output logic [31:0] w, output logic eoc);
        for (int i = 31; i >= 0; i--)
        begin
            w[i] = sdo;
            sck <= 1'b1;
            repeat (8) @(posedge clk);
            sck <= 1'b0;
            repeat (8) @(posedge clk);
        end
        repeat (4) @(posedge clk);
        eoc = sdo;
        cs_n <= 1'b1;
    endtask
    // internal clock mode: sck high at select fall, sample on each device rise
    task automatic read_int(output logic [31:0] w, output logic eoc, output logic ok);
        sck <= 1'b1;
        wait_ready(ok);
        for (int i = 31; i >= 0; i--)
        begin
            @(posedge sck_out);
            w[i] = sdo;
        end
        ok = ok && (sck_oe === 1'b1);
        @(negedge sck_out);
        repeat (2) @(posedge clk);
        eoc = sdo;
        cs_n <= 1'b1;
        sck  <= 1'b0;
    endtask
endmodule
